//--- inc/ccr_pkg.sv
// Purpose: Constants and types for the clock control register block.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, 25 MHz mclk.
// Notes:   Rules kept by the block and by software are listed below.
// Overview of operation
// - Writing 1 to the high-speed start task starts the crystal osc.
// - Writing 1 to the high-speed stop task stops the crystal osc.
// - Writing 1 to the low-speed start task starts the selected source.
// - Writing 1 to the low-speed stop task stops the low-speed source.
// - Writing 1 to the calibrate task begins an RC calibration run.
// - Calibration finishing raises the calibration-complete event flag.
// - High-speed run status shows the start task was triggered.
// - Low-speed run status shows the start task was triggered.
// - Low-speed start copies the source selection into a read-back copy.
// - Timer counts down from interval, times out at zero, then stops.
package ccr_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W          = 12;
   localparam logic [11:0] OFS_HF_START    = 12'h000;
   localparam logic [11:0] OFS_HF_STOP     = 12'h004;
   localparam logic [11:0] OFS_LF_START    = 12'h008;
   localparam logic [11:0] OFS_LF_STOP     = 12'h00c;
   localparam logic [11:0] OFS_CAL         = 12'h010;
   localparam logic [11:0] OFS_CT_START    = 12'h014;
   localparam logic [11:0] OFS_CT_STOP     = 12'h018;
   localparam logic [11:0] OFS_EV_HF       = 12'h100;
   localparam logic [11:0] OFS_EV_LF       = 12'h104;
   localparam logic [11:0] OFS_EV_DONE     = 12'h10c;
   localparam logic [11:0] OFS_EV_CAL_TIMER_TIMEOUT     = 12'h110;
   localparam logic [11:0] OFS_IRQ_SET     = 12'h304;
   localparam logic [11:0] OFS_IRQ_CLR     = 12'h308;
   localparam logic [11:0] OFS_IRQ_STAT    = 12'h30c;
   localparam logic [11:0] OFS_HF_RUN      = 12'h408;
   localparam logic [11:0] OFS_HF_STAT     = 12'h40c;
   localparam logic [11:0] OFS_LF_RUN      = 12'h414;
   localparam logic [11:0] OFS_LF_STAT     = 12'h418;
   localparam logic [11:0] OFS_LF_COPY     = 12'h41c;
   localparam logic [11:0] OFS_LF_SEL      = 12'h518;
   localparam logic [11:0] OFS_CT_IV       = 12'h538;

   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam int unsigned STATE_BIT       = 16;
   localparam int unsigned SRC_BYPASS_BIT  = 16;
   localparam int unsigned SRC_EXT_BIT     = 17;
   localparam logic [31:0] LF_SEL_MASK     = 32'h0003_0003;
   localparam logic [31:0] LF_SEL_RST      = 32'h0000_0000;
   localparam int unsigned EV_NUM          = 4;
   localparam int unsigned EV_HF           = 0;
   localparam int unsigned EV_LF           = 1;
   localparam int unsigned EV_DONE         = 2;
   localparam int unsigned EV_CAL_TIMER_TIMEOUT         = 3;
   localparam int unsigned CAL_TIMER_INTERVAL_W          = 7;
   localparam logic [6:0]  CAL_TIMER_INTERVAL_RST        = 7'h00;
   localparam int unsigned TICK_W          = 16;
   localparam int unsigned CT_TICK_DIV     = 16;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      BUS_IDLE   = 2'b00,
      BUS_ANSWER = 2'b01
   } ccr_bus_phase_t;

   typedef struct packed {
      logic       hf_enable;
      logic       lf_enable;
      logic       lf_external;
      logic       lf_bypass;
      logic [1:0] lf_src;
      logic       cal_active;
   } ccr_osc_ctrl_t;

   typedef struct packed {
      logic hf_running;
      logic lf_running;
      logic cal_finished;
   } ccr_osc_stat_t;

   typedef struct packed {
      logic              run;
      logic              tmo;
      logic [CAL_TIMER_INTERVAL_W-1:0] cnt;
      logic [TICK_W-1:0] div;
   } ccr_timer_t;

   typedef struct packed {
      ccr_bus_phase_t    phase;
      logic [31:0]       rdata;
      logic              hf_req;
      logic              lf_req;
      logic [31:0]       lf_sel;
      logic [31:0]       lf_copy;
      logic              cal_active;
      logic [EV_NUM-1:0] evt;
      logic [EV_NUM-1:0] irq_stat;
      logic [EV_NUM-1:0] irq_mask;
      logic [CAL_TIMER_INTERVAL_W-1:0] cal_timer_interval;
      logic              hf_run_d;
      logic              lf_run_d;
   } ccr_regs_t;

endpackage : ccr_pkg

//--- hw/ccr_cal_timer.sv
// Purpose: Calibration interval down-counter with its own tick divider.
// Assumes: start and stop are single-cycle pulses, never together.
// Notes:   Timeout is a one-cycle pulse from a flop.
module ccr_cal_timer
   import ccr_pkg::*;
#(
   parameter int unsigned TICK_DIV = CT_TICK_DIV
) (
   input  wire logic              mclk,
   input  wire logic              rstn,
   input  wire logic              start,
   input  wire logic              stop,
   input  wire logic [CAL_TIMER_INTERVAL_W-1:0] interval,
   output      logic              running,
   output      logic              timeout
);

   ccr_timer_t st_ff;
   ccr_timer_t nxt_st;
   logic       tick;

   // ----------------------------------------------------------------
   // Countdown
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st     = st_ff;
      nxt_st.tmo = 1'b0;
      tick       = (st_ff.div == TICK_W'(TICK_DIV - 1));
      if (st_ff.run) begin
         nxt_st.div = tick ? '0 : TICK_W'(st_ff.div + 1'b1);
      end else begin
         nxt_st.div = '0;
      end
      if (start) begin
         nxt_st.run = 1'b1;
         nxt_st.cnt = interval;
         nxt_st.div = '0;
      end else if (stop) begin
         nxt_st.run = 1'b0;
      end else if (st_ff.run && tick) begin
         // Zero interval times out on the first tick
         if (st_ff.cnt <= CAL_TIMER_INTERVAL_W'(1)) begin
            nxt_st.cnt = '0;
            nxt_st.run = 1'b0;
            nxt_st.tmo = 1'b1;
         end else begin
            nxt_st.cnt = CAL_TIMER_INTERVAL_W'(st_ff.cnt - 1'b1);
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign running = st_ff.run;
   assign timeout = st_ff.tmo;

endmodule : ccr_cal_timer

//--- hw/ccr_top.sv
// Purpose: Clock control task, event and status registers on Avalon-MM.
// Assumes: Analog oscillators report running levels and a calibration
//          finished pulse; all synchronous to mclk.
// Notes:   Every access takes two cycles: waitrequest high, then low.
module ccr_top
   import ccr_pkg::*;
#(
   parameter int unsigned TICK_DIV = CT_TICK_DIV
) (
   input  wire logic              mclk,
   input  wire logic              rstn,
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   output      logic [31:0]       avs_readdata,
   output      logic              avs_waitrequest,
   input  wire ccr_osc_stat_t     osc_stat,
   output      ccr_osc_ctrl_t     osc_ctrl,
   output      logic              irq
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] be_merge(
      input logic [31:0] old_val,
      input logic [31:0] new_val,
      input logic [3:0]  be
   );
      logic [31:0] res;
      res = old_val;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_val[i*8 +: 8];
         end
      end
      return res;
   endfunction : be_merge

   ccr_regs_t         st_ff;
   ccr_regs_t         nxt_st;
   logic              req;
   logic              commit;
   logic              ct_timeout;
   logic [31:0]       rd_val;
   logic [31:0]       sel_wr;
   logic [EV_NUM-1:0] ev_set;
   logic [EV_NUM-1:0] ev_clr;
   logic              t_hf_start;
   logic              t_hf_stop;
   logic              t_lf_start;
   logic              t_lf_stop;
   logic              t_cal;
   logic              t_ct_start;
   logic              t_ct_stop;

   // Task strobe: written word with byte 0 enabled and bit 0 set
   function automatic logic task_hit(
      input logic              wr,
      input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] ofs,
      input logic [3:0]        be,
      input logic [31:0]       wd
   );
      return wr && (addr == ofs) && be[0] && wd[0];
   endfunction : task_hit

   // Event clear: byte 0 enabled and bit 0 written as zero
   function automatic logic ev_zero(
      input logic              wr,
      input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] ofs,
      input logic [3:0]        be,
      input logic [31:0]       wd
   );
      return wr && (addr == ofs) && be[0] && !wd[0];
   endfunction : ev_zero

   // Rising edge of an oscillator running level
   function automatic logic rise_of(
      input logic cur,
      input logic prev
   );
      return cur && !prev;
   endfunction : rise_of

   // ----------------------------------------------------------------
   // Bus handshake
   // ----------------------------------------------------------------
   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req && (st_ff.phase == BUS_IDLE);
   assign commit          = avs_write && (st_ff.phase == BUS_ANSWER);
   assign avs_readdata    = st_ff.rdata;

   // ----------------------------------------------------------------
   // Task decode
   // ----------------------------------------------------------------
   always_comb begin
      t_hf_start = task_hit(commit, avs_address, OFS_HF_START,
                            avs_byteenable, avs_writedata);
      t_hf_stop  = task_hit(commit, avs_address, OFS_HF_STOP,
                            avs_byteenable, avs_writedata);
      t_lf_start = task_hit(commit, avs_address, OFS_LF_START,
                            avs_byteenable, avs_writedata);
      t_lf_stop  = task_hit(commit, avs_address, OFS_LF_STOP,
                            avs_byteenable, avs_writedata);
      t_cal      = task_hit(commit, avs_address, OFS_CAL,
                            avs_byteenable, avs_writedata);
      t_ct_start = task_hit(commit, avs_address, OFS_CT_START,
                            avs_byteenable, avs_writedata);
      t_ct_stop  = task_hit(commit, avs_address, OFS_CT_STOP,
                            avs_byteenable, avs_writedata);
   end

   // ----------------------------------------------------------------
   // Event sources and software clears
   // ----------------------------------------------------------------
   always_comb begin
      ev_set          = '0;
      ev_set[EV_HF]   = rise_of(osc_stat.hf_running, st_ff.hf_run_d);
      ev_set[EV_LF]   = rise_of(osc_stat.lf_running, st_ff.lf_run_d);
      ev_set[EV_DONE] = osc_stat.cal_finished && st_ff.cal_active;
      ev_set[EV_CAL_TIMER_TIMEOUT] = ct_timeout;
      ev_clr          = '0;
      ev_clr[EV_HF]   = ev_zero(commit, avs_address, OFS_EV_HF,
                                avs_byteenable, avs_writedata);
      ev_clr[EV_LF]   = ev_zero(commit, avs_address, OFS_EV_LF,
                                avs_byteenable, avs_writedata);
      ev_clr[EV_DONE] = ev_zero(commit, avs_address, OFS_EV_DONE,
                                avs_byteenable, avs_writedata);
      ev_clr[EV_CAL_TIMER_TIMEOUT] = ev_zero(commit, avs_address, OFS_EV_CAL_TIMER_TIMEOUT,
                                avs_byteenable, avs_writedata);
   end

   // ----------------------------------------------------------------
   // Read multiplexer
   // ----------------------------------------------------------------
   always_comb begin
      rd_val = 32'h0000_0000;
      case (avs_address)
         OFS_EV_HF: begin
            rd_val[0] = st_ff.evt[EV_HF];
         end
         OFS_EV_LF: begin
            rd_val[0] = st_ff.evt[EV_LF];
         end
         OFS_EV_DONE: begin
            rd_val[0] = st_ff.evt[EV_DONE];
         end
         OFS_EV_CAL_TIMER_TIMEOUT: begin
            rd_val[0] = st_ff.evt[EV_CAL_TIMER_TIMEOUT];
         end
         OFS_IRQ_SET, OFS_IRQ_CLR: begin
            rd_val[EV_NUM-1:0] = st_ff.irq_mask;
         end
         OFS_IRQ_STAT: begin
            rd_val[EV_NUM-1:0] = st_ff.irq_stat;
         end
         OFS_HF_RUN: begin
            rd_val[0] = st_ff.hf_req;
         end
         OFS_HF_STAT: begin
            rd_val[0]         = osc_stat.hf_running;
            rd_val[STATE_BIT] = osc_stat.hf_running;
         end
         OFS_LF_RUN: begin
            rd_val[0] = st_ff.lf_req;
         end
         OFS_LF_STAT: begin
            rd_val[1:0]       = st_ff.lf_copy[1:0];
            rd_val[STATE_BIT] = osc_stat.lf_running;
         end
         OFS_LF_COPY: begin
            rd_val = st_ff.lf_copy;
         end
         OFS_LF_SEL: begin
            rd_val = st_ff.lf_sel;
         end
         OFS_CT_IV: begin
            rd_val[CAL_TIMER_INTERVAL_W-1:0] = st_ff.cal_timer_interval;
         end
         // Task words and unmapped offsets read as zero
         default: begin
            rd_val = 32'h0000_0000;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st          = st_ff;
      nxt_st.hf_run_d = osc_stat.hf_running;
      nxt_st.lf_run_d = osc_stat.lf_running;
      sel_wr          = be_merge(st_ff.lf_sel, avs_writedata,
                                 avs_byteenable) & LF_SEL_MASK;

      case (st_ff.phase)
         BUS_IDLE: begin
            if (req) begin
               nxt_st.phase = BUS_ANSWER;
               nxt_st.rdata = avs_read ? rd_val : st_ff.rdata;
            end
         end
         BUS_ANSWER: begin
            nxt_st.phase = BUS_IDLE;
         end
         default: begin
            nxt_st.phase = BUS_IDLE;
         end
      endcase

      // High-speed crystal request
      if (t_hf_start) begin
         nxt_st.hf_req = 1'b1;
      end else if (t_hf_stop) begin
         nxt_st.hf_req = 1'b0;
      end

      // Low-speed source request and selection snapshot
      if (t_lf_start) begin
         nxt_st.lf_req  = 1'b1;
         nxt_st.lf_copy = st_ff.lf_sel;
      end else if (t_lf_stop) begin
         nxt_st.lf_req  = 1'b0;
      end

      // Calibration run ends on the analog finish pulse
      if (t_cal) begin
         nxt_st.cal_active = 1'b1;
      end else if (osc_stat.cal_finished) begin
         nxt_st.cal_active = 1'b0;
      end

      // Hardware set wins over a same-cycle software clear
      nxt_st.evt      = ev_set | (st_ff.evt & ~ev_clr);
      nxt_st.irq_stat = ev_set | st_ff.irq_stat;

      if (commit && avs_byteenable[0]) begin
         case (avs_address)
            OFS_IRQ_SET: begin
               nxt_st.irq_mask = st_ff.irq_mask |
                                 avs_writedata[EV_NUM-1:0];
            end
            OFS_IRQ_CLR: begin
               nxt_st.irq_mask = st_ff.irq_mask &
                                 ~avs_writedata[EV_NUM-1:0];
            end
            OFS_IRQ_STAT: begin
               nxt_st.irq_stat = ev_set | (st_ff.irq_stat &
                                 ~avs_writedata[EV_NUM-1:0]);
            end
            OFS_CT_IV: begin
               nxt_st.cal_timer_interval = avs_writedata[CAL_TIMER_INTERVAL_W-1:0];
            end
            default: begin
               nxt_st.irq_mask = st_ff.irq_mask;
            end
         endcase
      end

      // Selection is software's to keep still while the source runs
      if (commit && (avs_address == OFS_LF_SEL)) begin
         nxt_st.lf_sel = sel_wr;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_ff          <= '0;
         st_ff.phase    <= BUS_IDLE;
         st_ff.lf_sel   <= LF_SEL_RST;
         st_ff.lf_copy  <= LF_SEL_RST;
         st_ff.cal_timer_interval     <= CAL_TIMER_INTERVAL_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // Calibration timer
   // ----------------------------------------------------------------
   ccr_cal_timer #(
      .TICK_DIV (TICK_DIV)
   ) u_cal_timer (
      .mclk     (mclk),
      .rstn     (rstn),
      .start    (t_ct_start),
      .stop     (t_ct_stop),
      .interval (st_ff.cal_timer_interval),
      .running  (),
      .timeout  (ct_timeout)
   );

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_comb begin
      osc_ctrl             = '0;
      osc_ctrl.hf_enable   = st_ff.hf_req;
      osc_ctrl.lf_enable   = st_ff.lf_req;
      osc_ctrl.lf_src      = st_ff.lf_copy[1:0];
      osc_ctrl.lf_bypass   = st_ff.lf_copy[SRC_BYPASS_BIT];
      osc_ctrl.lf_external = st_ff.lf_copy[SRC_EXT_BIT];
      // Reference needs the crystal; a run without it never finishes
      osc_ctrl.cal_active  = st_ff.cal_active;
   end

   // Timer running is only visible through its timeout event
   assign irq = |(st_ff.irq_stat & st_ff.irq_mask);

endmodule : ccr_top

//--- testbench/ccr_top_properties.sv
// Purpose: Port-level assertions for the clock control registers.
// Assumes: A write commits at the edge where waitrequest is low.
// Notes:   Bound into ccr_top below the module.
module ccr_props
   import ccr_pkg::*;
#(
   parameter int unsigned TICK_DIV = CT_TICK_DIV
) (
   input wire logic              mclk,
   input wire logic              rstn,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic              avs_read,
   input wire logic              avs_write,
   input wire logic [31:0]       avs_writedata,
   input wire logic [3:0]        avs_byteenable,
   input wire logic [31:0]       avs_readdata,
   input wire logic              avs_waitrequest,
   input wire ccr_osc_stat_t     osc_stat,
   input wire ccr_osc_ctrl_t     osc_ctrl,
   input wire logic              irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr1;
   assign wr1 = avs_write && !avs_waitrequest && avs_byteenable[0]
                && avs_writedata[0];
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   hf_start_a:
      assert property (wr1 && avs_address == OFS_HF_START
         |=> osc_ctrl.hf_enable) else $error("hf start lost");
   hf_stop_a:
      assert property (wr1 && avs_address == OFS_HF_STOP
         |=> !osc_ctrl.hf_enable) else $error("hf stop lost");
   lf_start_a:
      assert property (wr1 && avs_address == OFS_LF_START
         |=> osc_ctrl.lf_enable) else $error("lf start lost");
   lf_stop_a:
      assert property (wr1 && avs_address == OFS_LF_STOP
         |=> !osc_ctrl.lf_enable) else $error("lf stop lost");
   cal_start_a:
      assert property (wr1 && avs_address == OFS_CAL
         |=> osc_ctrl.cal_active) else $error("cal start lost");
   cal_end_a:
      assert property (osc_stat.cal_finished && osc_ctrl.cal_active
         && !avs_write |=> !osc_ctrl.cal_active) else $error("cal stuck");
   task_zero_a:
      assert property (avs_read && !avs_waitrequest
         && avs_address <= OFS_CT_STOP |-> avs_readdata == 32'h0000_0000)
         else $error("task reads nonzero");
   zero_write_a:
      assert property (avs_write && !avs_waitrequest && !avs_writedata[0]
         && avs_address == OFS_HF_START |=> $stable(osc_ctrl.hf_enable))
         else $error("zero write acted");
endmodule : ccr_props

bind ccr_top ccr_props #(.TICK_DIV(TICK_DIV)) ccr_props_i (
   .mclk(mclk), .rstn(rstn), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .osc_stat(osc_stat), .osc_ctrl(osc_ctrl), .irq(irq));

//--- testbench/tb.sv
// Purpose: Self-checking bench for the clock control registers.
// Assumes: TICK_DIV of 2 keeps the timer runs short.
// Notes:   Bus tasks look at waitrequest on the falling edge.
module tb
   import ccr_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned TD = 2;
   logic              mclk;
   logic              rstn;
   logic [ADDR_W-1:0] avs_address;
   logic              avs_read;
   logic              avs_write;
   logic [31:0]       avs_writedata;
   logic [3:0]        avs_byteenable;
   logic [31:0]       avs_readdata;
   logic              avs_waitrequest;
   ccr_osc_stat_t     osc_stat;
   ccr_osc_ctrl_t     osc_ctrl;
   logic              irq;
   int                miscompares;
   int                compares;
   always #20 mclk = ~mclk;
   ccr_top #(.TICK_DIV(TD)) ccr_top_i (.mclk(mclk), .rstn(rstn),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .osc_stat(osc_stat),
      .osc_ctrl(osc_ctrl), .irq(irq));
   task finish_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s got %h", $time, m, got);
      end
   endtask : chk
   // One access; released one edge after completion so strobes never
   // get assigned twice in one time step.
   task bus(input logic rd, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q);
      int n;
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= rd;
      avs_write <= !rd;
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (avs_waitrequest !== 1'b0) begin
         miscompares++;
         finish_test();
      end
      q = avs_readdata;
      @(posedge mclk);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask : bus
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b0, a, d, q);
   endtask : wr
   task rdchk(input logic [11:0] a, input logic [31:0] e, input string m);
      logic [31:0] q;
      bus(1'b1, a, 32'h0000_0000, q);
      chk(q, e, m);
   endtask : rdchk
   task edges(input int k);
      repeat (k) @(posedge mclk);
   endtask : edges
   task t_reset;
      logic [11:0] al[14];
      al = '{OFS_HF_START, OFS_CAL, OFS_CT_STOP, OFS_EV_HF, OFS_EV_LF,
             OFS_EV_DONE, OFS_EV_CAL_TIMER_TIMEOUT, OFS_IRQ_SET, OFS_HF_RUN,
             OFS_LF_RUN, OFS_LF_COPY, OFS_LF_SEL, OFS_CT_IV, 12'h0f0};
      foreach (al[i]) begin
         rdchk(al[i], 32'h0000_0000, "reset value");
      end
      $display("test reset done");
   endtask : t_reset
   task t_hf;
      wr(OFS_HF_START, 32'h0000_0000);
      chk(osc_ctrl.hf_enable, 1'b0, "zero write");
      wr(OFS_HF_START, 32'h0000_0001);
      chk(osc_ctrl.hf_enable, 1'b1, "hf on");
      // Oscillator still reports stopped: run flag must not care
      rdchk(OFS_HF_RUN, 32'h0000_0001, "hf run");
      rdchk(OFS_HF_START, 32'h0000_0000, "task read");
      wr(OFS_HF_STOP, 32'h0000_0001);
      chk(osc_ctrl.hf_enable, 1'b0, "hf off");
      $display("test hf done");
   endtask : t_hf
   task t_lf;
      wr(OFS_LF_SEL, 32'h0003_0001);
      wr(OFS_LF_START, 32'h0000_0001);
      chk(osc_ctrl.lf_enable, 1'b1, "lf on");
      chk({osc_ctrl.lf_external, osc_ctrl.lf_bypass, osc_ctrl.lf_src},
          4'b1101, "lf src");
      rdchk(OFS_LF_RUN, 32'h0000_0001, "lf run");
      rdchk(OFS_LF_COPY, 32'h0003_0001, "copy");
      wr(OFS_LF_STOP, 32'h0000_0001);
      chk(osc_ctrl.lf_enable, 1'b0, "lf off");
      wr(OFS_LF_SEL, 32'h0000_0002);
      rdchk(OFS_LF_COPY, 32'h0003_0001, "copy held");
      $display("test lf done");
   endtask : t_lf
   task t_cal;
      wr(OFS_IRQ_SET, 32'h0000_0004);
      wr(OFS_HF_START, 32'h0000_0001);
      wr(OFS_CAL, 32'h0000_0001);
      chk(osc_ctrl.cal_active, 1'b1, "cal on");
      chk(irq, 1'b0, "irq idle");
      osc_stat.cal_finished <= 1'b1;
      edges(1);
      osc_stat.cal_finished <= 1'b0;
      edges(2);
      chk(osc_ctrl.cal_active, 1'b0, "cal end");
      chk(irq, 1'b1, "irq done");
      rdchk(OFS_EV_DONE, 32'h0000_0001, "done");
      rdchk(OFS_EV_DONE, 32'h0000_0001, "done sticky");
      wr(OFS_EV_DONE, 32'h0000_0000);
      rdchk(OFS_EV_DONE, 32'h0000_0000, "done clear");
      wr(OFS_IRQ_CLR, 32'h0000_0004);
      chk(irq, 1'b0, "irq masked");
      wr(OFS_IRQ_STAT, 32'h0000_0004);
      wr(OFS_IRQ_SET, 32'h0000_0004);
      chk(irq, 1'b0, "irq cleared");
      $display("test cal done");
   endtask : t_cal
   task t_timer;
      int n;
      wr(OFS_IRQ_SET, 32'h0000_0008);
      wr(OFS_CT_IV, 32'h0000_0005);
      wr(OFS_CT_START, 32'h0000_0001);
      n = 0;
      // Look at irq while settled, half a cycle after each edge
      while (irq !== 1'b1 && n < 40) begin
         @(negedge mclk);
         n++;
      end
      if (n >= 40) begin
         miscompares++;
         finish_test();
      end
      edges(1);
      // Five ticks of TD cycles, then one cycle into the event flop
      chk(n, 5 * TD + 1, "ct time");
      rdchk(OFS_EV_CAL_TIMER_TIMEOUT, 32'h0000_0001, "cal_timer_timeout");
      wr(OFS_EV_CAL_TIMER_TIMEOUT, 32'h0000_0000);
      wr(OFS_IRQ_STAT, 32'h0000_0008);
      wr(OFS_CT_IV, 32'h0000_0014);
      wr(OFS_CT_START, 32'h0000_0001);
      // A timer tick stands in for one low-speed period
      edges(TD);
      wr(OFS_CT_STOP, 32'h0000_0001);
      edges(60);
      rdchk(OFS_EV_CAL_TIMER_TIMEOUT, 32'h0000_0000, "ct stopped");
      chk(irq, 1'b0, "no cal_timer_timeout irq");
      $display("test timer done");
   endtask : t_timer
   initial begin
      mclk = 1'b0;
      rstn = 1'b0;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      avs_byteenable = 4'hf;
      osc_stat = '0;
      miscompares = 0;
      compares = 0;
      edges(6);
      rstn <= 1'b1;
      edges(1);
      t_reset();
      t_hf();
      t_lf();
      t_cal();
      t_timer();
      finish_test();
   end
endmodule : tb
